// >>> core/frws_pkg.sv
// Shared constants of the flash row write sequencer
package frws_pkg;

    // ==========================================================
    // Register byte offsets on the APB slave
    localparam logic [7:0] OFS_ADDR_LOW  = 8'h00;
    localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;
    localparam logic [7:0] OFS_DATA_LOW  = 8'h08;
    localparam logic [7:0] OFS_DATA_HIGH = 8'h0C;
    localparam logic [7:0] OFS_CONTROL   = 8'h10;
    localparam logic [7:0] OFS_UNLOCK    = 8'h14;

    // ==========================================================
    // Control and address high register field positions
    localparam int BIT_GO       = 1;
    localparam int BIT_PROG_EN  = 2;
    localparam int BIT_ERR      = 3;
    localparam int BIT_LATCH_LO = 5;
    localparam int BIT_CFG_SEL  = 6;
    localparam int BIT_CTRL_ONE = 7;
    localparam int BIT_ADRH_ONE = 7;

    // ==========================================================
    // Address field positions
    localparam int ADDR_ROW_LO_POS = 5;
    localparam int ADDR_HIGH_W     = 7;

    // ==========================================================
    // Unlock keys and values after reset
    localparam logic [7:0]  KEY_FIRST   = 8'h55;
    localparam logic [7:0]  KEY_SECOND  = 8'hAA;
    localparam logic [13:0] BLANK_WORD  = 14'h3FFF;
    localparam logic [7:0]  RST_BYTE    = 8'h00;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ       = 100;
    localparam int PROG_TIME_US  = 2000;
    localparam int PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
    localparam int NOP_CYCLES    = 2;

    // ==========================================================
    // State encodings
    typedef enum logic [1:0] {UNL_IDLE, UNL_KEY1, UNL_KEY2} frws_unlock_t;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_NOP, SEQ_PROG} frws_seq_t;

endpackage

// >>> core/frws_top.sv
// Flash row write sequencer: APB registers, unlock check, write latches, row programming
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
// ==========================================================
// How it works
// - Row from upper ten address bits, latch from lower five
// - Programming touches only the captured row
// - Latches return blank after each row write
// - Latches return blank after each erase
// - No automatic erase before programming
// - One to thirty-two words per program
// - Latch-only go loads one latch, no write
// - Otherwise load latch then program whole row
// - No load or program without unlock first
// - Interrupted unlock starts nothing
// - Two forced no-ops, then stall for row program
// - Go is set-only, hardware clears it
// - Program enable clear inhibits all programming
module frws_top #(
    parameter int NUM_LATCHES = 32,
    parameter int WORD_W      = 14,
    parameter int PROG_CYCLES = frws_pkg::PROG_CYCLES
) (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [7:0]                    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Neighbouring erase logic
    input  wire logic                          erase_done,
    // Processor core
    output logic                               cpu_nop_force,
    output logic                               cpu_stall,
    // Flash array
    output logic                               flash_prog,
    output logic      [9:0]                    flash_row_q,
    output logic      [NUM_LATCHES*WORD_W-1:0] flash_latch_data
);

    localparam int IDX_W = $clog2(NUM_LATCHES);
    localparam int CNT_W = $clog2(PROG_CYCLES + 1);

    // ==========================================================
    // Elaboration checks
    // Row and latch fields are fixed at ten and five bits, so other sizes cannot be served
    if (NUM_LATCHES != 32 || WORD_W != 14 || PROG_CYCLES < 1)
    begin : g_bad_params
        $error("frws_top: latch count, word width or program time unsupported");
    end

    // ==========================================================
    // APB decode
    logic         xfer;
    logic         wr;
    logic         hit;
    logic [7:0]   wbyte;

    assign xfer    = psel & penable;
    assign wr      = xfer & pwrite;
    assign pready  = 1'b1;
    assign wbyte   = pwdata[7:0];
    assign hit     = (paddr == frws_pkg::OFS_ADDR_LOW)  || (paddr == frws_pkg::OFS_ADDR_HIGH) ||
                     (paddr == frws_pkg::OFS_DATA_LOW)  || (paddr == frws_pkg::OFS_DATA_HIGH) ||
                     (paddr == frws_pkg::OFS_CONTROL)   || (paddr == frws_pkg::OFS_UNLOCK);
    assign pslverr = xfer & ~hit;

    // ==========================================================
    // Address and data pairs
    localparam int ADDR_HIGH_W = frws_pkg::ADDR_HIGH_W;
    logic [7:0]              flash_addr_low_q;
    logic [ADDR_HIGH_W-1:0]  flash_addr_high_q;
    logic [7:0]              flash_data_low_q;
    logic [WORD_W-9:0]       flash_data_high_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            flash_addr_low_q  <= frws_pkg::RST_BYTE;
            flash_addr_high_q <= frws_pkg::RST_BYTE[ADDR_HIGH_W-1:0];
            flash_data_low_q  <= frws_pkg::RST_BYTE;
            flash_data_high_q <= frws_pkg::RST_BYTE[WORD_W-9:0];
        end
        else if (wr)
        begin
            if (paddr == frws_pkg::OFS_ADDR_LOW)
                flash_addr_low_q <= wbyte;
            if (paddr == frws_pkg::OFS_ADDR_HIGH)
                flash_addr_high_q <= wbyte[ADDR_HIGH_W-1:0];
            if (paddr == frws_pkg::OFS_DATA_LOW)
                flash_data_low_q <= wbyte;
            if (paddr == frws_pkg::OFS_DATA_HIGH)
                flash_data_high_q <= wbyte[WORD_W-9:0];
        end
    end

    // ==========================================================
    // Control bits
    logic program_enable_q;
    logic config_space_select_q;
    logic latch_only_load_q;
    logic err_q;
    logic go_q;
    logic go_wr;
    logic accept;
    logic seq_done;
    frws_pkg::frws_unlock_t unl_q;
    frws_pkg::frws_seq_t    seq_q;

    assign go_wr  = wr && (paddr == frws_pkg::OFS_CONTROL) && wbyte[frws_pkg::BIT_GO];
    // Config space writes belong to neighbouring logic, so they never start a row write
    assign accept = go_wr && !go_q && (unl_q == frws_pkg::UNL_KEY2)
                    && program_enable_q && !config_space_select_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            program_enable_q      <= 1'b0;
            config_space_select_q <= 1'b0;
            latch_only_load_q     <= 1'b0;
        end
        else if (wr && (paddr == frws_pkg::OFS_CONTROL))
        begin
            program_enable_q      <= wbyte[frws_pkg::BIT_PROG_EN];
            config_space_select_q <= wbyte[frws_pkg::BIT_CFG_SEL];
            latch_only_load_q     <= wbyte[frws_pkg::BIT_LATCH_LO];
        end
    end

    // Go is set only through an accepted unlock and cleared only by the sequencer
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            go_q <= 1'b0;
        else if (accept)
            go_q <= 1'b1;
        else if (seq_done)
            go_q <= 1'b0;
    end

    // Error flag: a rejected go attempt sets it, software writes zero to clear; set wins
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            err_q <= 1'b0;
        else if (go_wr && !go_q && !accept)
            err_q <= 1'b1;
        else if (wr && (paddr == frws_pkg::OFS_CONTROL) && !wbyte[frws_pkg::BIT_ERR])
            err_q <= 1'b0;
    end

    // ==========================================================
    // Unlock tracker: any transfer other than the expected next step starts over
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            unl_q <= frws_pkg::UNL_IDLE;
        else if (xfer)
        begin
            if (wr && (paddr == frws_pkg::OFS_UNLOCK) && wbyte == frws_pkg::KEY_FIRST)
                unl_q <= frws_pkg::UNL_KEY1;
            else if (wr && (paddr == frws_pkg::OFS_UNLOCK) && wbyte == frws_pkg::KEY_SECOND
                     && unl_q == frws_pkg::UNL_KEY1)
                unl_q <= frws_pkg::UNL_KEY2;
            else
                unl_q <= frws_pkg::UNL_IDLE;
        end
    end

    // ==========================================================
    // Sequencer
    logic [CNT_W-1:0] cnt_q;
    logic             row_mode_q;
    logic [IDX_W-1:0] latch_idx;
    logic [9:0]       row_sel;

    // Upper ten bits pick the row, lower five the latch
    assign latch_idx = flash_addr_low_q[IDX_W-1:0];
    assign row_sel   = {flash_addr_high_q, flash_addr_low_q[7:frws_pkg::ADDR_ROW_LO_POS]};
    assign seq_done  = ((seq_q == frws_pkg::SEQ_NOP) && (cnt_q == CNT_W'(1)) && !row_mode_q) ||
                       ((seq_q == frws_pkg::SEQ_PROG) && (cnt_q == CNT_W'(1)));

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            seq_q      <= frws_pkg::SEQ_IDLE;
            cnt_q      <= '0;
            row_mode_q <= 1'b0;
        end
        else
        begin
            case (seq_q)
                frws_pkg::SEQ_IDLE:
                begin
                    if (accept)
                    begin
                        seq_q      <= frws_pkg::SEQ_NOP;
                        cnt_q      <= CNT_W'(frws_pkg::NOP_CYCLES);
                        row_mode_q <= !latch_only_load_q;
                    end
                end
                frws_pkg::SEQ_NOP:
                begin
                    if (cnt_q == CNT_W'(1))
                    begin
                        // Row program writes latches over existing cells, no erase step
                        seq_q <= row_mode_q ? frws_pkg::SEQ_PROG : frws_pkg::SEQ_IDLE;
                        cnt_q <= CNT_W'(PROG_CYCLES);
                    end
                    else
                        cnt_q <= cnt_q - CNT_W'(1);
                end
                frws_pkg::SEQ_PROG:
                begin
                    if (cnt_q == CNT_W'(1))
                        seq_q <= frws_pkg::SEQ_IDLE;
                    else
                        cnt_q <= cnt_q - CNT_W'(1);
                end
                default:
                    seq_q <= frws_pkg::SEQ_IDLE;
            endcase
        end
    end

    assign cpu_nop_force = (seq_q == frws_pkg::SEQ_NOP);
    assign cpu_stall     = (seq_q == frws_pkg::SEQ_PROG);
    assign flash_prog    = (seq_q == frws_pkg::SEQ_PROG);

    // Row is captured at go so later address writes cannot move a running program
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            flash_row_q <= '0;
        else if (accept)
            flash_row_q <= row_sel;
    end

    // ==========================================================
    // Write latches
    logic [WORD_W-1:0] latch_q [NUM_LATCHES];
    logic              row_end;

    assign row_end = (seq_q == frws_pkg::SEQ_PROG) && (cnt_q == CNT_W'(1));

    genvar gi;
    generate
        for (gi = 0; gi < NUM_LATCHES; gi++)
        begin : g_latch
            always_ff @(posedge clk)
            begin
                if (!rst_n || row_end || erase_done)
                    latch_q[gi] <= frws_pkg::BLANK_WORD;
                else if (accept && (latch_idx == IDX_W'(gi)))
                    latch_q[gi] <= {flash_data_high_q, flash_data_low_q};
            end
            assign flash_latch_data[gi*WORD_W +: WORD_W] = latch_q[gi];
        end
    endgenerate

    // ==========================================================
    // Read data
    always_comb
    begin
        prdata = '0;
        case (paddr)
            frws_pkg::OFS_ADDR_LOW:  prdata[7:0] = flash_addr_low_q;
            frws_pkg::OFS_ADDR_HIGH: prdata[7:0] = {1'b1, flash_addr_high_q};
            frws_pkg::OFS_DATA_LOW:  prdata[7:0] = flash_data_low_q;
            frws_pkg::OFS_DATA_HIGH: prdata[7:0] = {2'b00, flash_data_high_q};
            frws_pkg::OFS_CONTROL:
            begin
                prdata[frws_pkg::BIT_CTRL_ONE] = 1'b1;
                prdata[frws_pkg::BIT_CFG_SEL]  = config_space_select_q;
                prdata[frws_pkg::BIT_LATCH_LO] = latch_only_load_q;
                prdata[frws_pkg::BIT_ERR]      = err_q;
                prdata[frws_pkg::BIT_PROG_EN]  = program_enable_q;
                prdata[frws_pkg::BIT_GO]       = go_q;
            end
            default: prdata = '0;
        endcase
    end

    // ==========================================================
    // Assertions
    logic all_blank;
    always_comb
    begin
        all_blank = 1'b1;
        for (int i = 0; i < NUM_LATCHES; i++)
            if (latch_q[i] != frws_pkg::BLANK_WORD)
                all_blank = 1'b0;
    end

    chk_row_select: assert property (@(posedge clk) disable iff (!rst_n)
        accept |=> flash_row_q == $past(row_sel))
        else $error("row not taken from upper address bits");
    chk_row_hold: assert property (@(posedge clk) disable iff (!rst_n)
        flash_prog && $past(flash_prog) |-> $stable(flash_row_q))
        else $error("row moved during programming");
    chk_blank_write: assert property (@(posedge clk) disable iff (!rst_n)
        row_end |=> all_blank && seq_q == frws_pkg::SEQ_IDLE)
        else $error("latches not blank after row write");
    chk_blank_erase: assert property (@(posedge clk) disable iff (!rst_n)
        erase_done |=> all_blank)
        else $error("latches not blank after erase");
    chk_latch_only: assert property (@(posedge clk) disable iff (!rst_n)
        accept && latch_only_load_q |=> !flash_prog [*3] ##1 !go_q)
        else $error("latch-only load started a row write");
    chk_row_start: assert property (@(posedge clk) disable iff (!rst_n)
        accept && !latch_only_load_q |-> ##3 flash_prog && go_q)
        else $error("row write not started after forced no-ops");
    chk_no_unlock: assert property (@(posedge clk) disable iff (!rst_n)
        go_wr && unl_q != frws_pkg::UNL_KEY2 |=> seq_q == frws_pkg::SEQ_IDLE && !go_q)
        else $error("operation started without unlock");
    chk_key_order: assert property (@(posedge clk) disable iff (!rst_n)
        xfer && unl_q == frws_pkg::UNL_KEY2 |=> unl_q != frws_pkg::UNL_KEY2)
        else $error("unlock survived an extra transfer");
    chk_nop_two: assert property (@(posedge clk) disable iff (!rst_n)
        accept |=> cpu_nop_force [*2] ##1 !cpu_nop_force)
        else $error("forced no-op window not two cycles");
    chk_enable_gate: assert property (@(posedge clk) disable iff (!rst_n)
        go_wr && !program_enable_q |=> !go_q && !cpu_nop_force)
        else $error("operation started with program enable clear");
    chk_go_clear: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(go_q) |-> $past(seq_done))
        else $error("go cleared before operation end");

    cov_latch_load: cover property (@(posedge clk) disable iff (!rst_n)
        accept && latch_only_load_q);
    cov_row_prog: cover property (@(posedge clk) disable iff (!rst_n) row_end);
    cov_broken_unlock: cover property (@(posedge clk) disable iff (!rst_n)
        go_wr && unl_q == frws_pkg::UNL_KEY1);

endmodule

// >>> verif/frws_cpu_model.sv
// Processor core model that runs the self-write software over APB
`timescale 1ns/1ps
module frws_cpu_model (
    // Clock
    input  wire logic        clk,
    // APB master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // Core hold from the sequencer
    input  wire logic        cpu_nop_force,
    input  wire logic        cpu_stall
);
    int   idle_cycles = 0;
    logic last_err;

    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'hFF;
        pwdata  = 32'hFFFFFFFF;
    end

    // ==========================================================
    // One transfer; a slow core leaves idle cycles before it
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                        output logic [31:0] rdata);
        repeat (idle_cycles + 1) @(posedge clk);
        // Forced no-ops and a row stall keep the core from issuing anything
        while (cpu_nop_force === 1'b1 || cpu_stall === 1'b1)
            @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= {24'h000000, wdata};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rdata    = prdata;
        last_err = pslverr;
        // Released address and data lines never keep showing the old value; pwrite keeps it
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~addr;
        pwdata  <= ~{24'h000000, wdata};
    endtask

    // ==========================================================
    // Enable, flash space, latch-only unless last, address, data, keys, go
    task automatic load_word(input logic [7:0] ah, al, dl, dh, input logic last);
        logic [31:0] rd;
        logic [7:0]  ctrl;
        ctrl = last ? 8'h04 : 8'h24;
        xfer(1'b1, frws_pkg::OFS_CONTROL, ctrl, rd);
        xfer(1'b1, frws_pkg::OFS_ADDR_HIGH, ah, rd);
        xfer(1'b1, frws_pkg::OFS_ADDR_LOW, al, rd);
        xfer(1'b1, frws_pkg::OFS_DATA_LOW, dl, rd);
        xfer(1'b1, frws_pkg::OFS_DATA_HIGH, dh, rd);
        xfer(1'b1, frws_pkg::OFS_UNLOCK, frws_pkg::KEY_FIRST, rd);
        xfer(1'b1, frws_pkg::OFS_UNLOCK, frws_pkg::KEY_SECOND, rd);
        xfer(1'b1, frws_pkg::OFS_CONTROL, ctrl | 8'h02, rd);
    endtask
endmodule

// >>> verif/frws_top_test.sv
// Self-checking bench for the flash row write sequencer
`timescale 1ns/1ps
module frws_top_test;
    localparam int         NL    = 32;
    localparam int         WW    = 14;
    localparam int         PROG  = 20;
    localparam logic [7:0] A_CTL = frws_pkg::OFS_CONTROL;
    localparam logic [7:0] A_UNL = frws_pkg::OFS_UNLOCK;
    typedef logic [NL*WW-1:0] frws_vec_t;

    logic        clk;
    logic        rst_n;
    logic        erase_done;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cpu_nop_force;
    logic        cpu_stall;
    logic        flash_prog;
    logic [9:0]  flash_row_q;
    frws_vec_t   flash_latch_data;
    frws_vec_t   exp_lat;
    logic [31:0] rd;
    int          miscompares = 0;
    int          n_tests = 0;

    frws_top #(.NUM_LATCHES(NL), .WORD_W(WW), .PROG_CYCLES(PROG)) dut (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .erase_done(erase_done), .cpu_nop_force(cpu_nop_force),
        .cpu_stall(cpu_stall), .flash_prog(flash_prog), .flash_row_q(flash_row_q),
        .flash_latch_data(flash_latch_data));
    frws_cpu_model cpu (
        .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_nop_force(cpu_nop_force), .cpu_stall(cpu_stall));

    initial clk = 1'b0;
    always #5 clk = ~clk;

    // ==========================================================
    // Comparison, verdict and shared helpers
    task automatic check(input frws_vec_t seen, input frws_vec_t exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        if (miscompares == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        cpu.xfer(1'b0, addr, 8'h00, rd);
        check(frws_vec_t'(rd), frws_vec_t'(exp));
    endtask
    // Counts forced no-ops, then stall cycles that coincide with the program window
    task automatic watch_go(input int exp_nop, input int exp_prog);
        int n;
        int m;
        n = 0;
        m = 0;
        #1;
        while (cpu_nop_force === 1'b1 && n < 8)
        begin
            n++;
            @(posedge clk);
            #1;
        end
        check(frws_vec_t'(n), frws_vec_t'(exp_nop));
        check(flash_latch_data, exp_lat);
        n = 0;
        while (flash_prog === 1'b1 && m < 4 * PROG)
        begin
            m++;
            n += int'(cpu_stall === 1'b1);
            @(posedge clk);
            #1;
        end
        check(frws_vec_t'({m, n}), frws_vec_t'({exp_prog, exp_prog}));
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        check(flash_latch_data, exp_lat);
        check(frws_vec_t'({cpu_nop_force, cpu_stall, flash_prog}), frws_vec_t'(0));
        rd_chk(frws_pkg::OFS_ADDR_HIGH, 32'h00000080);
        rd_chk(A_CTL, 32'h00000080);
        cpu.xfer(1'b0, 8'h18, 8'h00, rd);
        check(frws_vec_t'({cpu.last_err, rd}), frws_vec_t'(33'h100000000));
    endtask
    // Top address bit outside the row field, data high bits beyond the word
    task automatic t_latch_load;
        exp_lat[3*WW +: WW] = 14'h152A;
        cpu.load_word(8'hC5, 8'h23, 8'h2A, 8'hD5, 1'b0);
        watch_go(2, 0);
        rd_chk(A_CTL, 32'h000000A4);
    endtask
    task automatic t_row;
        exp_lat[31*WW +: WW] = 14'h3C01;
        cpu.load_word(8'hC5, 8'h3F, 8'h01, 8'h3C, 1'b1);
        watch_go(2, PROG);
        check(frws_vec_t'(flash_row_q), frws_vec_t'(10'h229));
        exp_lat = {NL{frws_pkg::BLANK_WORD}};
        check(flash_latch_data, exp_lat);
        rd_chk(A_CTL, 32'h00000084);
    endtask
    // No keys, interrupted keys, swapped keys, disabled, config space
    task automatic t_refuse;
        logic [7:0] base;
        cpu.xfer(1'b1, frws_pkg::OFS_ADDR_LOW, 8'h07, rd);
        cpu.xfer(1'b1, frws_pkg::OFS_DATA_LOW, 8'h11, rd);
        for (int k = 0; k < 5; k++)
        begin
            base = (k == 3) ? 8'h20 : ((k == 4) ? 8'h64 : 8'h24);
            cpu.xfer(1'b1, A_CTL, base, rd);
            if (k == 2)
                cpu.xfer(1'b1, A_UNL, frws_pkg::KEY_SECOND, rd);
            if (k != 0)
                cpu.xfer(1'b1, A_UNL, frws_pkg::KEY_FIRST, rd);
            if (k == 1)
                cpu.xfer(1'b0, frws_pkg::OFS_ADDR_LOW, 8'h00, rd);
            if (k != 0 && k != 2)
                cpu.xfer(1'b1, A_UNL, frws_pkg::KEY_SECOND, rd);
            cpu.xfer(1'b1, A_CTL, base | 8'h02, rd);
            watch_go(0, 0);
            cpu.xfer(1'b0, A_CTL, 8'h00, rd);
            check(frws_vec_t'(rd & 32'h0000000A), frws_vec_t'(32'h8));
        end
    endtask
    // Slow core; erase blanks a loaded latch, then a one-word row program
    task automatic t_erase;
        cpu.idle_cycles = 2;
        exp_lat[7*WW +: WW] = 14'h2211;
        cpu.load_word(8'h00, 8'hE7, 8'h11, 8'h22, 1'b0);
        watch_go(2, 0);
        @(posedge clk);
        erase_done <= 1'b1;
        @(posedge clk);
        erase_done <= 1'b0;
        exp_lat = {NL{frws_pkg::BLANK_WORD}};
        #1;
        check(flash_latch_data, exp_lat);
        exp_lat[7*WW +: WW] = 14'h0155;
        cpu.load_word(8'h00, 8'hE7, 8'h55, 8'hC1, 1'b1);
        watch_go(2, PROG);
        check(frws_vec_t'(flash_row_q), frws_vec_t'(10'h007));
        cpu.idle_cycles = 0;
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial
    begin
        rst_n      = 1'b0;
        erase_done = 1'b0;
        exp_lat    = {NL{frws_pkg::BLANK_WORD}};
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_latch_load();
        t_row();
        t_refuse();
        t_erase();
        summarize();
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        summarize();
    end
endmodule
